//--- logic/soirq_defs.svh
// Register selects, field positions and reset values of the shift and
// interrupt block.
// Assumes inclusion by bare name from every file that needs the constants.
`ifndef SOIRQ_DEFS_SVH
`define SOIRQ_DEFS_SVH

// ==========================================================
// Register selects
`define SOIRQ_RS_SR 4'ha
`define SOIRQ_RS_ACR 4'hb
`define SOIRQ_RS_IFR 4'hd
`define SOIRQ_RS_IER 4'he

// ==========================================================
// Field positions
`define SOIRQ_ACR_MODE_HI 4
`define SOIRQ_ACR_MODE_LO 2
`define SOIRQ_FLAG_SHIFT 2
`define SOIRQ_SUMMARY_BIT 7
`define SOIRQ_BIT_LAST 3'h7
`define SOIRQ_BIT_FIRST 3'h0

// ==========================================================
// Reset values and fixed read values
`define SOIRQ_SR_RESET 8'h00
`define SOIRQ_ACR_RESET 8'h00
`define SOIRQ_FLAGS_RESET 7'h00
`define SOIRQ_ENABLES_RESET 7'h00
`define SOIRQ_RDATA_NONE 8'h00
`define SOIRQ_IER_TOP 1'b1

`endif

//--- logic/soirq_pkg.sv
// Types shared by the shift and interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package soirq_pkg;

  // ==========================================================
  // Shift modes held in the control register
  typedef enum logic [2:0] {
    SOIRQ_MODE_OFF = 3'b000,
    SOIRQ_MODE_IN_T2 = 3'b001,
    SOIRQ_MODE_IN_BUS = 3'b010,
    SOIRQ_MODE_IN_EXT = 3'b011,
    SOIRQ_MODE_OUT_FREE = 3'b100,
    SOIRQ_MODE_OUT_T2 = 3'b101,
    SOIRQ_MODE_OUT_BUS = 3'b110,
    SOIRQ_MODE_OUT_EXT = 3'b111
  } soirq_mode_e;

  // ==========================================================
  // Internally clocked shifter states
  typedef enum logic [1:0] {
    SOIRQ_IDLE = 2'b00,
    SOIRQ_WAIT = 2'b01,
    SOIRQ_RUN = 2'b10
  } soirq_run_e;

endpackage

`default_nettype wire

//--- logic/soirq_flag_if.sv
// Carrier between the shift logic and the flag and enable store.
// Assumes both ends run on the bus clock.
`timescale 1ns/1ps
`default_nettype none

interface soirq_flag_if;
  logic [6:0] set_evt;
  logic [6:0] clr_evt;
  logic en_wr;
  logic [7:0] en_wdata;
  logic [6:0] flags;
  logic [6:0] enables;
  logic any;

  // Store side
  modport core (
    input set_evt,
    input clr_evt,
    input en_wr,
    input en_wdata,
    output flags,
    output enables,
    output any
  );

  // Control side
  modport ctrl (
    output set_evt,
    output clr_evt,
    output en_wr,
    output en_wdata,
    input flags,
    input enables,
    input any
  );
endinterface

`default_nettype wire

//--- logic/soirq_link_sync.sv
// Turns rising edges of the external shift clock into bus clock pulses.
// Assumes pulses are spaced at least a few bus clocks apart.
`timescale 1ns/1ps
`default_nettype none

module soirq_link_sync (
  input wire logic link_clk,
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic edge_pulse
);
  logic toggle_q;
  logic meta_q;
  logic sync_q;
  logic seen_q;

  // ==========================================================
  // Link side: one toggle per external edge
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      toggle_q <= 1'b0;
    else
      toggle_q <= ~toggle_q;
  end

  // ==========================================================
  // Bus side: two-stage synchroniser then change detect
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      meta_q <= toggle_q;
      sync_q <= meta_q;
      seen_q <= sync_q;
    end
  end

  // One pulse per crossed toggle
  assign edge_pulse = sync_q ^ seen_q;

endmodule // soirq_link_sync

`default_nettype wire

//--- logic/soirq_irq_core.sv
// Interrupt flag and enable store with the request summary.
// Assumes set and clear events are one-cycle pulses on the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "soirq_defs.svh"

module soirq_irq_core (
  input wire logic ref_clk,
  input wire logic arst_n,
  soirq_flag_if.core fi
);
  logic [6:0] flags_q;
  logic [6:0] enables_q;

  // ==========================================================
  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      flags_q <= `SOIRQ_FLAGS_RESET;
    else
      flags_q <= (flags_q & ~fi.clr_evt) | fi.set_evt;
  end

  // Enables: top data bit picks set or clear of the marked bits
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      enables_q <= `SOIRQ_ENABLES_RESET;
    else if (fi.en_wr && fi.en_wdata[`SOIRQ_SUMMARY_BIT])
      enables_q <= enables_q | fi.en_wdata[6:0];
    else if (fi.en_wr)
      enables_q <= enables_q & ~fi.en_wdata[6:0];
  end

  // Summary of flagged and enabled sources
  assign fi.flags = flags_q;
  assign fi.enables = enables_q;
  assign fi.any = |(flags_q & enables_q);

  // ==========================================================
  // Checks
  chk_flag_clear_one:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (flags_q & $past(fi.clr_evt & ~fi.set_evt)) == 7'h00)
    else $error("flag written with one did not clear");

  chk_flag_sticky_hold:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> ((flags_q & $past(flags_q & ~fi.clr_evt))
                == $past(flags_q & ~fi.clr_evt)))
    else $error("flag dropped without a clear");

  chk_enable_set_bits:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      fi.en_wr && fi.en_wdata[7] |=>
        enables_q == ($past(enables_q) | $past(fi.en_wdata[6:0])))
    else $error("enable set write wrong");

  chk_enable_clr_bits:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      fi.en_wr && !fi.en_wdata[7] |=>
        enables_q == ($past(enables_q) & ~$past(fi.en_wdata[6:0])))
    else $error("enable clear write wrong");

endmodule // soirq_irq_core

`default_nettype wire

//--- logic/soirq_shift_irq.sv
// Shift-out modes 5 to 7 and the interrupt request of the adapter.
// Assumes bus requests are one-cycle strobes on ref_clk, the timer time-out
// is a ref_clk pulse, and the external shift clock is its own domain.
`timescale 1ns/1ps
`default_nettype none
`include "soirq_defs.svh"

// Behaviour
// - Mode 5 paces by timer two; starts at once if flag already set.
// - Mode 5 access resets bit count; eight bits and eight clock pulses.
// - Mode 5 stops after eighth pulse, sets flag, data pin holds.
// - Mode 6 takes its shift rate from the bus clock.
// - Mode 7 shifts on external pulses, flags every eight, keeps going.
// - Mode 7 access clears the shift flag and restarts the count.
// - Flags are set by events and stay until explicitly cleared.
// - Request line low when any flag meets its enable.
// - Request line is open-collector for wire-OR sharing.
// - Flag read bit 7 is the OR of enabled flags.
// - Writing one to a flag bit clears it; zeros keep.
// - Writing bit 7 of the flags has no direct effect.
// - Enable write with bit 7 low clears marked enables.
// - Enable write with bit 7 high sets marked enables.
// - Enables always readable; bit 7 reads as one.
// - Selected register read drives its contents on the data bus.
// - A modulo-8 bit counter governs each shift operation.
module soirq_shift_irq (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bus_cs,
  input wire logic [3:0] bus_rs,
  input wire logic bus_rw,
  input wire logic bus_strobe,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata_q,
  output logic bus_rvalid_q,
  input wire logic timer2_timeout,
  input wire logic [6:0] event_flags,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out_q,
  output logic shift_clock_pin_oe_n_q,
  output logic shift_data_pin_out_q,
  output logic shift_data_pin_oe_n_q,
  output logic irq_n_out_q,
  output logic irq_n_oe_n_q
);
  logic [7:0] serial_shift_reg_q;
  logic [7:0] acr_q;
  logic [2:0] bit_cnt_q;
  logic kick_q;
  soirq_pkg::soirq_run_e state_q;
  soirq_pkg::soirq_mode_e mode_w;
  logic rd_w;
  logic wr_w;
  logic sr_access_w;
  logic m5_w;
  logic m6_w;
  logic m7_w;
  logic ext_pulse_w;
  logic step_w;
  logic fall_step_w;
  logic rise_step_w;
  logic last_rise_w;
  logic m7_step_w;
  logic m7_wrap_w;
  logic shift_flag_w;

  soirq_flag_if flag_bus ();

  // ==========================================================
  // Register select decode
  function automatic logic sel(input logic [3:0] rs, input logic [3:0] want);
    sel = bus_strobe && bus_cs && (rs == want);
  endfunction

  assign rd_w = bus_strobe && bus_cs && bus_rw;
  assign wr_w = bus_strobe && bus_cs && !bus_rw;
  assign sr_access_w = sel(bus_rs, `SOIRQ_RS_SR);
  assign mode_w = soirq_pkg::soirq_mode_e'(
    acr_q[`SOIRQ_ACR_MODE_HI:`SOIRQ_ACR_MODE_LO]);
  assign m5_w = (mode_w == soirq_pkg::SOIRQ_MODE_OUT_T2);
  assign m6_w = (mode_w == soirq_pkg::SOIRQ_MODE_OUT_BUS);
  assign m7_w = (mode_w == soirq_pkg::SOIRQ_MODE_OUT_EXT);
  assign shift_flag_w = flag_bus.flags[`SOIRQ_FLAG_SHIFT];

  // ==========================================================
  // External shift clock crossing
  soirq_link_sync u_sync (
    .link_clk(shift_clock_pin_in),
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .edge_pulse(ext_pulse_w)
  );

  // ==========================================================
  // Step decode: timer or bus clock paces internal modes
  assign step_w = !sr_access_w && (kick_q
    || (state_q == soirq_pkg::SOIRQ_RUN && m6_w)
    || (state_q != soirq_pkg::SOIRQ_IDLE && m5_w && timer2_timeout));
  assign fall_step_w = step_w && shift_clock_pin_out_q;
  assign rise_step_w = step_w && !shift_clock_pin_out_q;
  assign last_rise_w = rise_step_w && (bit_cnt_q == `SOIRQ_BIT_LAST);
  assign m7_step_w = m7_w && ext_pulse_w && !sr_access_w;
  assign m7_wrap_w = m7_step_w && (bit_cnt_q == `SOIRQ_BIT_LAST);

  // Flag store connections
  always_comb
  begin
    flag_bus.set_evt = event_flags;
    flag_bus.set_evt[`SOIRQ_FLAG_SHIFT] = last_rise_w || m7_wrap_w;
    flag_bus.clr_evt = 7'h00;
    if (wr_w && bus_rs == `SOIRQ_RS_IFR)
      flag_bus.clr_evt = bus_wdata[6:0];
    if (sr_access_w)
      flag_bus.clr_evt[`SOIRQ_FLAG_SHIFT] = 1'b1;
    flag_bus.en_wr = wr_w && (bus_rs == `SOIRQ_RS_IER);
    flag_bus.en_wdata = bus_wdata;
  end

  soirq_irq_core u_core (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .fi(flag_bus.core)
  );

  // ==========================================================
  // Shifter state for timer and bus clock modes
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= soirq_pkg::SOIRQ_IDLE;
    else if (sr_access_w && m6_w)
      state_q <= soirq_pkg::SOIRQ_RUN;
    else if (sr_access_w && m5_w)
      state_q <= shift_flag_w ? soirq_pkg::SOIRQ_RUN
                              : soirq_pkg::SOIRQ_WAIT;
    else if (!(m5_w || m6_w))
      state_q <= soirq_pkg::SOIRQ_IDLE;
    else
    begin
      case (state_q)
        soirq_pkg::SOIRQ_WAIT:
          if (step_w)
            state_q <= soirq_pkg::SOIRQ_RUN;
        soirq_pkg::SOIRQ_RUN:
          if (last_rise_w)
            state_q <= soirq_pkg::SOIRQ_IDLE;
        soirq_pkg::SOIRQ_IDLE:
          state_q <= soirq_pkg::SOIRQ_IDLE;
        default:
          state_q <= soirq_pkg::SOIRQ_IDLE;
      endcase
    end
  end

  // Immediate start when the flag was already set
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      kick_q <= 1'b0;
    else
      kick_q <= sr_access_w && m5_w && shift_flag_w;
  end

  // Modulo-8 bit counter
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      bit_cnt_q <= `SOIRQ_BIT_FIRST;
    else if (sr_access_w)
      bit_cnt_q <= `SOIRQ_BIT_FIRST;
    else if (rise_step_w || m7_step_w)
      bit_cnt_q <= bit_cnt_q + 3'h1;
  end

  // Shift register: load on write, rotate MSB first on each shift
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      serial_shift_reg_q <= `SOIRQ_SR_RESET;
    else if (sr_access_w && !bus_rw)
      serial_shift_reg_q <= bus_wdata;
    else if (fall_step_w || m7_step_w)
      serial_shift_reg_q <= {serial_shift_reg_q[6:0],
                             serial_shift_reg_q[7]};
  end

  // Data pin: next bit out, held after the last shift
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_data_pin_out_q <= 1'b1;
      shift_data_pin_oe_n_q <= 1'b1;
    end
    else
    begin
      shift_data_pin_oe_n_q <= !(m5_w || m6_w || m7_w);
      if (fall_step_w || m7_step_w)
        shift_data_pin_out_q <= serial_shift_reg_q[7];
    end
  end

  // Clock pin: driven in modes 5 and 6, idles high
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_clock_pin_out_q <= 1'b1;
      shift_clock_pin_oe_n_q <= 1'b1;
    end
    else
    begin
      shift_clock_pin_oe_n_q <= !(m5_w || m6_w);
      if (sr_access_w || !(m5_w || m6_w))
        shift_clock_pin_out_q <= 1'b1;
      else if (step_w)
        shift_clock_pin_out_q <= !shift_clock_pin_out_q;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      acr_q <= `SOIRQ_ACR_RESET;
    else if (wr_w && bus_rs == `SOIRQ_RS_ACR)
      acr_q <= bus_wdata;
  end

  // Read data for the selected register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_rdata_q <= `SOIRQ_RDATA_NONE;
      bus_rvalid_q <= 1'b0;
    end
    else
    begin
      bus_rvalid_q <= rd_w;
      if (rd_w)
      begin
        case (bus_rs)
          `SOIRQ_RS_SR: bus_rdata_q <= serial_shift_reg_q;
          `SOIRQ_RS_ACR: bus_rdata_q <= acr_q;
          `SOIRQ_RS_IFR: bus_rdata_q <= {flag_bus.any, flag_bus.flags};
          `SOIRQ_RS_IER: bus_rdata_q <= {`SOIRQ_IER_TOP,
                                         flag_bus.enables};
          default: bus_rdata_q <= `SOIRQ_RDATA_NONE;
        endcase
      end
    end
  end

  // Open-collector request: only ever pulls low
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_n_out_q <= 1'b0;
      irq_n_oe_n_q <= 1'b1;
    end
    else
    begin
      irq_n_out_q <= 1'b0;
      irq_n_oe_n_q <= !flag_bus.any;
    end
  end

  // ==========================================================
  // Checks
  chk_irq_pin_match:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> irq_n_oe_n_q == !$past(flag_bus.any))
    else $error("request line does not follow enabled flags");

  chk_irq_never_high:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      irq_n_out_q == 1'b0)
    else $error("request line driven high");

  chk_flag_read_top:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_w && bus_rs == `SOIRQ_RS_IFR |=>
        bus_rvalid_q && bus_rdata_q[7] == !irq_n_oe_n_q)
    else $error("flag read top bit differs from request line");

  chk_enable_read_one:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_w && bus_rs == `SOIRQ_RS_IER |=> bus_rdata_q[7])
    else $error("enable read top bit not one");

  chk_count_steps:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> bit_cnt_q == $past(bit_cnt_q) || bit_cnt_q == 3'h0
        || bit_cnt_q == $past(bit_cnt_q) + 3'h1)
    else $error("bit counter jumped");

  chk_m5_end_flag:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      last_rise_w |=> state_q == soirq_pkg::SOIRQ_IDLE && shift_flag_w
        && shift_clock_pin_out_q)
    else $error("shift end did not stop and flag");

  chk_m7_restart:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      sr_access_w && m7_w && !flag_bus.set_evt[`SOIRQ_FLAG_SHIFT] |=>
        bit_cnt_q == 3'h0 && !shift_flag_w)
    else $error("access in mode 7 did not restart");

  chk_msb_first_out:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      fall_step_w || m7_step_w |=>
        shift_data_pin_out_q == $past(serial_shift_reg_q[7]))
    else $error("data pin not fed from bit 7");

  chk_m6_at_once:
    assert property (@(posedge ref_clk) disable iff (!arst_n)
      sr_access_w && m6_w |=> shift_clock_pin_out_q ##1
        !shift_clock_pin_out_q ##1 shift_clock_pin_out_q)
    else $error("mode 6 did not start at bus rate");

endmodule // soirq_shift_irq

`default_nettype wire

//--- tb/soirq_far_model.sv
// Far-side serial device on the shift clock and shift data pins.
// Assumes the bench calls pulses() only while the device listens (mode 7).
`timescale 1ns/1ps
`default_nettype none

module soirq_far_model (
  input wire logic clk_out,
  input wire logic clk_oe_n,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic clr,
  output wire logic pin,
  output logic [7:0] cap,
  output logic [4:0] n
);
  logic ext_clk = 1'b1;
  logic data_seen;

  // Pin level: device clock when it drives, else our own clock
  assign pin = clk_oe_n ? ext_clk : clk_out;
  // A released data line shows the inverse of the last bit taken
  assign data_seen = data_oe_n ? ~cap[0] : data_out;

  // ==========================================================
  // Capture with a device-made clock, modes 5 and 6
  always @(posedge pin)
  begin
    if (!clk_oe_n)
    begin
      cap = {cap[6:0], data_seen};
      n = n + 5'h01;
    end
  end

  // Clear the capture between bytes
  always @(posedge clr)
  begin
    cap = 8'h00;
    n = 5'h00;
  end

  // ==========================================================
  // External clock pulses at 32 ns; clock rests high between frames so
  // that handing the pin over to the device makes no false rising edge
  task automatic pulses(input int k);
    repeat (k)
    begin
      ext_clk = 1'b0;
      #16;
      ext_clk = 1'b1;
      #16;
      cap = {cap[6:0], data_seen}; // Sample once the step has landed
      n = n + 5'h01;
    end
  endtask
endmodule // soirq_far_model

`default_nettype wire

//--- tb/soirq_shift_irq_tb.sv
// Self-checking bench for the shift-out modes and the interrupt logic.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "soirq_defs.svh"

module soirq_shift_irq_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic bus_cs = 1'b0;
  logic [3:0] bus_rs = 4'h0;
  logic bus_rw = 1'b1;
  logic bus_strobe = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic timer2_timeout = 1'b0;
  logic [6:0] event_flags = 7'h00;
  logic clr = 1'b0;
  logic [7:0] rv;
  int n_mismatch = 0;
  int cmp_count = 0;
  wire logic [7:0] rdata;
  wire logic rvalid;
  wire logic pin;
  wire logic ck_out;
  wire logic ck_oe_n;
  wire logic d_out;
  wire logic d_oe_n;
  wire logic irq_out;
  wire logic irq_oe_n;
  wire logic irq_wire;
  wire logic [7:0] cap;
  wire logic [4:0] n_edge;

  // Request line with its pull-up
  assign irq_wire = irq_oe_n ? 1'b1 : irq_out;

  // Bus clock, 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  soirq_shift_irq i_dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .bus_cs(bus_cs),
    .bus_rs(bus_rs),
    .bus_rw(bus_rw),
    .bus_strobe(bus_strobe),
    .bus_wdata(bus_wdata),
    .bus_rdata_q(rdata),
    .bus_rvalid_q(rvalid),
    .timer2_timeout(timer2_timeout),
    .event_flags(event_flags),
    .shift_clock_pin_in(pin),
    .shift_clock_pin_out_q(ck_out),
    .shift_clock_pin_oe_n_q(ck_oe_n),
    .shift_data_pin_out_q(d_out),
    .shift_data_pin_oe_n_q(d_oe_n),
    .irq_n_out_q(irq_out),
    .irq_n_oe_n_q(irq_oe_n)
  );

  soirq_far_model i_far (
    .clk_out(ck_out),
    .clk_oe_n(ck_oe_n),
    .data_out(d_out),
    .data_oe_n(d_oe_n),
    .clr(clr),
    .pin(pin),
    .cap(cap),
    .n(n_edge)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // One strobe cycle; read data taken with the valid pulse
  task automatic acc(input logic [3:0] rs, input logic rw,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk);
    #1;
    bus_cs = 1'b1;
    bus_rs = rs;
    bus_rw = rw;
    bus_wdata = wd;
    bus_strobe = 1'b1;
    cyc(1);
    bus_strobe = 1'b0;
    bus_cs = 1'b0;
    rd = rvalid ? rdata : 8'hxx;
  endtask

  task automatic wr(input logic [3:0] rs, input logic [7:0] wd);
    logic [7:0] d;
    acc(rs, 1'b0, wd, d);
  endtask

  task automatic rd(input logic [3:0] rs, input logic [7:0] e);
    logic [7:0] d;
    acc(rs, 1'b1, 8'h00, d);
    chk(d, e);
  endtask

  // Timer time-outs, one-cycle pulses four cycles apart
  task automatic tmo(input int k);
    repeat (k)
    begin
      timer2_timeout = 1'b1;
      cyc(1);
      timer2_timeout = 1'b0;
      cyc(3);
    end
  endtask

  task automatic clear_cap();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({ck_oe_n, d_oe_n, irq_wire, d_out}, 8'h0f);
    rd(`SOIRQ_RS_IFR, 8'h00);
    rd(`SOIRQ_RS_IER, 8'h80);
    rd(4'h0, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_mode6();
    wr(`SOIRQ_RS_ACR, {3'b000, soirq_pkg::SOIRQ_MODE_OUT_BUS, 2'b00});
    clear_cap();
    wr(`SOIRQ_RS_SR, 8'ha5);
    cyc(20);
    chk(cap, 8'ha5);
    chk({3'b000, n_edge}, 8'h08);
    chk({7'h00, d_out}, 8'h01);
    rd(`SOIRQ_RS_IFR, 8'h04);
    $display("test mode6 done");
  endtask

  task automatic t_irq();
    chk({7'h00, irq_out}, 8'h00);
    wr(`SOIRQ_RS_IER, 8'h84);
    rd(`SOIRQ_RS_IER, 8'h84);
    chk({7'h00, irq_wire}, 8'h00);
    rd(`SOIRQ_RS_IFR, 8'h84);
    wr(`SOIRQ_RS_IFR, 8'h80);
    rd(`SOIRQ_RS_IFR, 8'h84);
    wr(`SOIRQ_RS_IER, 8'h04);
    rd(`SOIRQ_RS_IER, 8'h80);
    cyc(1);
    chk({7'h00, irq_wire}, 8'h01);
    rd(`SOIRQ_RS_IFR, 8'h04);
    wr(`SOIRQ_RS_IFR, 8'h04);
    rd(`SOIRQ_RS_IFR, 8'h00);
    event_flags = 7'h41;
    cyc(1);
    event_flags = 7'h00;
    cyc(4);
    rd(`SOIRQ_RS_IFR, 8'h41);
    wr(`SOIRQ_RS_IER, 8'h81);
    cyc(1);
    chk({7'h00, irq_wire}, 8'h00);
    wr(`SOIRQ_RS_IFR, 8'h01);
    rd(`SOIRQ_RS_IFR, 8'h40);
    chk({7'h00, irq_wire}, 8'h01);
    wr(`SOIRQ_RS_IER, 8'h7f);
    wr(`SOIRQ_RS_IFR, 8'h7f);
    $display("test irq done");
  endtask

  task automatic t_mode5();
    wr(`SOIRQ_RS_ACR, {3'b000, soirq_pkg::SOIRQ_MODE_OUT_T2, 2'b00});
    clear_cap();
    wr(`SOIRQ_RS_SR, 8'h3c);
    cyc(8);
    chk({3'b000, n_edge}, 8'h00);
    tmo(16);
    chk(cap, 8'h3c);
    chk({3'b000, n_edge}, 8'h08);
    chk({7'h00, d_out}, 8'h00);
    rd(`SOIRQ_RS_IFR, 8'h04);
    clear_cap();
    rd(`SOIRQ_RS_SR, 8'h3c);
    cyc(3);
    chk({7'h00, ck_out}, 8'h00);
    tmo(16);
    chk({3'b000, n_edge}, 8'h08);
    $display("test mode5 done");
  endtask

  task automatic t_mode7();
    wr(`SOIRQ_RS_ACR, {3'b000, soirq_pkg::SOIRQ_MODE_OUT_EXT, 2'b00});
    wr(`SOIRQ_RS_SR, 8'h96);
    rd(`SOIRQ_RS_IFR, 8'h00);
    clear_cap();
    i_far.pulses(8);
    cyc(6);
    chk(cap, 8'h96);
    rd(`SOIRQ_RS_IFR, 8'h04);
    i_far.pulses(8);
    cyc(6);
    chk(cap, 8'h96);
    wr(`SOIRQ_RS_SR, 8'h5a);
    rd(`SOIRQ_RS_IFR, 8'h00);
    i_far.pulses(3);
    cyc(6);
    wr(`SOIRQ_RS_SR, 8'hc3);
    clear_cap();
    i_far.pulses(7);
    cyc(6);
    rd(`SOIRQ_RS_IFR, 8'h00);
    i_far.pulses(1);
    cyc(6);
    rd(`SOIRQ_RS_IFR, 8'h04);
    chk(cap, 8'hc3);
    $display("test mode7 done");
  endtask

  // ==========================================================
  // Verdict and end of run
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well past the expected few hundred cycles
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_mode6();
    t_irq();
    t_mode5();
    t_mode7();
    finish_test();
  end
endmodule // soirq_shift_irq_tb

`default_nettype wire
